// file: rtl/ddsl_pkg.sv
/*
  Shared constants for the dual converter serial load block: word layout,
  target codes, register offsets and reset values.
  Assumes a 32-bit AHB-Lite register bus and a 16-bit serial word.
*/
package ddsl_pkg;

  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam int CNT_W  = 5;

  // Word layout
  localparam int BIT_TGT_HI = 15;
  localparam int BIT_SPEED  = 14;
  localparam int BIT_PWR    = 13;
  localparam int BIT_TGT_LO = 12;
  localparam int CODE_MSB   = 11;
  localparam int CODE_LSB   = 2;
  localparam int REF_HI     = 1;
  localparam int REF_LO     = 0;
  localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;

  typedef enum logic [1:0] {
    DDSL_TGT_B_STAGE = 2'b00,
    DDSL_TGT_STAGE   = 2'b01,
    DDSL_TGT_A_XFER  = 2'b10,
    DDSL_TGT_CONFIG  = 2'b11
  } ddsl_target_t;

  // Register byte offsets
  localparam logic [7:0] OFS_DAC_A    = 8'h00;
  localparam logic [7:0] OFS_DAC_B    = 8'h04;
  localparam logic [7:0] OFS_STAGE    = 8'h08;
  localparam logic [7:0] OFS_CONFIG   = 8'h0C;
  localparam logic [7:0] OFS_LAST     = 8'h10;
  localparam logic [7:0] OFS_CONTROL  = 8'h14;
  localparam logic [7:0] OFS_SW_LOAD  = 8'h18;
  localparam logic [7:0] OFS_COUNT    = 8'h1C;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST    = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RST    = 16'h0000;
  localparam logic              CTRL_EN_RST = 1'b1;

endpackage : ddsl_pkg

// file: rtl/ddsl_link_if.sv
/*
  Signals from the serial front end to the register-side core.
  Front end side runs on the serial clock; the core re-times the toggles and reads shift_word directly once it stands still.
*/
`timescale 1ns/10ps
interface ddsl_link_if;
  logic [ddsl_pkg::WORD_W-1:0] shift_word;
  logic                        frame_tgl;
  logic                        full_tgl;

  modport front (output shift_word, output frame_tgl, output full_tgl);
  modport core  (input  shift_word, input  frame_tgl, input  full_tgl);
endinterface : ddsl_link_if

// file: rtl/ddsl_serial_front.sv
/*
  Serial front end on the serial clock: shifts data on falling edges,
  flags a full word on the following rising edge.
  Assumes select meets setup to the serial clock; clock edges that
  arrive while select is high are ignored.
*/
`timescale 1ns/10ps
module ddsl_serial_front (
  // Reset
  input wire logic hresetn,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // To core
  ddsl_link_if.front link
);

  logic [ddsl_pkg::CNT_W-1:0] bit_cnt_reg;
  logic                       full_sent_reg;
  logic                       clr;

  assign clr = !hresetn || cs_n;

  // Bit counter cleared while select is high
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg != ddsl_pkg::FULL_COUNT) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Shift MSB first, stop after the sixteenth bit
  always_ff @(negedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      link.shift_word <= ddsl_pkg::WORD_RST;
    end else if (!cs_n && bit_cnt_reg != ddsl_pkg::FULL_COUNT) begin // RULE_01 RULE_14
      link.shift_word <= {link.shift_word[ddsl_pkg::WORD_W-2:0], din};
    end
  end

  // Frame marker toggles on the first bit of each frame
  always_ff @(negedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      link.frame_tgl <= 1'b0;
    end else if (!cs_n && bit_cnt_reg == 5'h00) begin
      link.frame_tgl <= !link.frame_tgl;
    end
  end

  // Full word announced on the rising edge after the last bit
  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      full_sent_reg <= 1'b0;
    end else if (bit_cnt_reg == ddsl_pkg::FULL_COUNT) begin
      full_sent_reg <= 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      link.full_tgl <= 1'b0;
    end else if (!cs_n && bit_cnt_reg == ddsl_pkg::FULL_COUNT && !full_sent_reg) begin // RULE_08
      link.full_tgl <= !link.full_tgl;
    end
  end

endmodule : ddsl_serial_front

// file: rtl/ddsl_top.sv
/*
  Dual converter serial load block: serial front end, word commit, target
  latches and an AHB-Lite register slave.
  Assumes a host that frames words with select low; hclk is free running,
  the serial clock may stop outside frames.
*/
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// Function
// [RULE_01] Once select is low, each falling serial clock edge shifts one data bit in, MSB first.
// [RULE_02] The word is committed after sixteen bits, or earlier when select rises.
// [RULE_03] Control bits in the word choose channel A, channel B, staging or configuration latch.
// [RULE_04] Conversion codes use bits 11 down to 2 only; the two lowest bits are dropped.
// [RULE_05] Power-on reset clears every latch to zero.
// [RULE_06] The host pulls select low before it clocks any data bit.
// [RULE_07] An 8-bit host port sends two bytes within one select low period.
// [RULE_08] A full word updates its latch on the sixteenth rising serial clock edge.
// [RULE_09] The host keeps select low past the sixteenth falling edge.
// [RULE_10] Bits 15..12 are target high, speed, power, target low; bits 11..0 are data.
// [RULE_11] Code 00 writes B and staging, 01 staging, 10 writes A and moves staging to B, 11 configuration.
// [RULE_12] Speed bit 1 means fast, power bit 1 means power down.
// [RULE_13] Configuration bits 1..0 select the reference: 00 and 11 external, 01 low, 10 high internal.
// [RULE_14] Serial clock edges with select high and bits after the sixteenth are ignored.
module ddsl_top (
  // Clock and reset
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  // AHB-Lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic      [31:0]                       hrdata,
  // Serial link
  input  wire logic                              sclk,
  input  wire logic                              cs_n,
  input  wire logic                              din,
  // Converter controls
  output logic      [ddsl_pkg::CODE_W-1:0]       dac_a_code,
  output logic      [ddsl_pkg::CODE_W-1:0]       dac_b_code,
  output logic                                   speed_fast,
  output logic                                   power_down,
  output logic      [1:0]                        ref_select,
  output logic                                   update_pulse
);

  function automatic logic [ddsl_pkg::CODE_W-1:0] code_of(input logic [ddsl_pkg::WORD_W-1:0] w);
    code_of = w[ddsl_pkg::CODE_MSB:ddsl_pkg::CODE_LSB]; // RULE_04
  endfunction : code_of

  function automatic ddsl_pkg::ddsl_target_t target_of(input logic [ddsl_pkg::WORD_W-1:0] w);
    target_of = ddsl_pkg::ddsl_target_t'({w[ddsl_pkg::BIT_TGT_HI], w[ddsl_pkg::BIT_TGT_LO]}); // RULE_10
  endfunction : target_of

  ddsl_link_if link ();

  ddsl_serial_front u_front (
    .hresetn (hresetn),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .din     (din),
    .link    (link.front)
  );

  // Synchronisers into hclk
  logic [1:0] cs_sync_reg;
  logic [1:0] frame_sync_reg;
  logic [1:0] full_sync_reg;
  logic       cs_seen_reg;
  logic       full_seen_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_sync_reg    <= 2'h3;
      frame_sync_reg <= 2'h0;
      full_sync_reg  <= 2'h0;
    end else begin
      cs_sync_reg    <= {cs_sync_reg[0], cs_n};
      frame_sync_reg <= {frame_sync_reg[0], link.frame_tgl};
      full_sync_reg  <= {full_sync_reg[0], link.full_tgl};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_seen_reg   <= 1'b1;
      full_seen_reg <= 1'b0;
    end else begin
      cs_seen_reg   <= cs_sync_reg[1];
      full_seen_reg <= full_sync_reg[1];
    end
  end

  logic full_event;
  logic cs_rise_event;

  assign full_event    = full_sync_reg[1] != full_seen_reg;
  assign cs_rise_event = cs_sync_reg[1] && !cs_seen_reg;

  // Frame bookkeeping: a frame is committed once, by full word or by select rise
  logic done_tgl_reg;
  logic frame_open;

  assign frame_open = frame_sync_reg[1] != done_tgl_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_tgl_reg <= 1'b0;
    end else if (full_event || cs_rise_event) begin
      done_tgl_reg <= frame_sync_reg[1];
    end
  end

  // Serial word stays still after the last bit or once select is high
  logic serial_commit;

  assign serial_commit = full_event || (cs_rise_event && frame_open); // RULE_02 RULE_08

  // Software control and load
  logic                        link_en_reg;
  logic                        sw_pend_reg;
  logic [ddsl_pkg::WORD_W-1:0] sw_word_reg;
  logic                        sw_write;
  logic                        ctrl_write;

  // Commit selection, serial first
  logic                        commit_valid;
  logic [ddsl_pkg::WORD_W-1:0] commit_word;
  logic                        sw_taken;

  always_comb begin
    commit_valid = 1'b0;
    commit_word  = ddsl_pkg::WORD_RST;
    sw_taken     = 1'b0;
    if (serial_commit && link_en_reg) begin
      commit_valid = 1'b1;
      commit_word  = link.shift_word;
    end else if (sw_pend_reg) begin
      commit_valid = 1'b1;
      commit_word  = sw_word_reg;
      sw_taken     = 1'b1;
    end
  end

  // Target latches
  logic [ddsl_pkg::CODE_W-1:0] dac_a_reg;
  logic [ddsl_pkg::CODE_W-1:0] dac_b_reg;
  logic [ddsl_pkg::CODE_W-1:0] stage_reg;
  logic                        speed_reg;
  logic                        power_reg;
  logic [1:0]                  ref_reg;
  logic [ddsl_pkg::WORD_W-1:0] last_word_reg;
  logic [15:0]                 word_cnt_reg;
  logic                        update_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_a_reg <= ddsl_pkg::CODE_RST; // RULE_05
      dac_b_reg <= ddsl_pkg::CODE_RST;
      stage_reg <= ddsl_pkg::CODE_RST;
    end else if (commit_valid) begin
      case (target_of(commit_word)) // RULE_03 RULE_11
        ddsl_pkg::DDSL_TGT_B_STAGE: begin
          dac_b_reg <= code_of(commit_word);
          stage_reg <= code_of(commit_word);
        end
        ddsl_pkg::DDSL_TGT_STAGE: begin
          stage_reg <= code_of(commit_word);
        end
        ddsl_pkg::DDSL_TGT_A_XFER: begin
          dac_a_reg <= code_of(commit_word);
          dac_b_reg <= stage_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // Speed and power ride on every word; reference only on configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_reg <= 1'b0;
      power_reg <= 1'b0;
    end else if (commit_valid) begin
      speed_reg <= commit_word[ddsl_pkg::BIT_SPEED]; // RULE_12
      power_reg <= commit_word[ddsl_pkg::BIT_PWR];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_reg <= 2'h0;
    end else if (commit_valid && target_of(commit_word) == ddsl_pkg::DDSL_TGT_CONFIG) begin
      ref_reg <= {commit_word[ddsl_pkg::REF_HI], commit_word[ddsl_pkg::REF_LO]}; // RULE_13
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_word_reg <= ddsl_pkg::WORD_RST;
      word_cnt_reg  <= 16'h0000;
      update_reg    <= 1'b0;
    end else begin
      update_reg <= commit_valid;
      if (commit_valid) begin
        last_word_reg <= commit_word;
        word_cnt_reg  <= word_cnt_reg + 16'h0001;
      end
    end
  end

  assign dac_a_code   = dac_a_reg;
  assign dac_b_code   = dac_b_reg;
  assign speed_fast   = speed_reg;
  assign power_down   = power_reg;
  assign ref_select   = ref_reg;
  assign update_pulse = update_reg;

  // AHB-Lite address phase capture
  logic       addr_valid;
  logic       dp_write_reg;
  logic [7:0] dp_addr_reg;

  assign addr_valid = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_write_reg <= addr_valid && hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  assign ctrl_write = dp_write_reg && dp_addr_reg == ddsl_pkg::OFS_CONTROL;
  assign sw_write   = dp_write_reg && dp_addr_reg == ddsl_pkg::OFS_SW_LOAD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_en_reg <= ddsl_pkg::CTRL_EN_RST;
    end else if (ctrl_write) begin
      link_en_reg <= hwdata[0];
    end
  end

  // A new software word replaces one still waiting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_pend_reg <= 1'b0;
      sw_word_reg <= ddsl_pkg::WORD_RST;
    end else if (sw_write) begin
      sw_pend_reg <= 1'b1;
      sw_word_reg <= hwdata[ddsl_pkg::WORD_W-1:0];
    end else if (sw_taken) begin
      sw_pend_reg <= 1'b0;
    end
  end

  // Read data registered at the address phase
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (haddr[7:0])
      ddsl_pkg::OFS_DAC_A:   rdata_next[ddsl_pkg::CODE_W-1:0] = dac_a_reg;
      ddsl_pkg::OFS_DAC_B:   rdata_next[ddsl_pkg::CODE_W-1:0] = dac_b_reg;
      ddsl_pkg::OFS_STAGE:   rdata_next[ddsl_pkg::CODE_W-1:0] = stage_reg;
      ddsl_pkg::OFS_CONFIG:  rdata_next[3:0] = {power_reg, speed_reg, ref_reg};
      ddsl_pkg::OFS_LAST:    rdata_next[ddsl_pkg::WORD_W-1:0] = last_word_reg;
      ddsl_pkg::OFS_CONTROL: rdata_next[1:0] = {sw_pend_reg, link_en_reg};
      ddsl_pkg::OFS_COUNT:   rdata_next[15:0] = word_cnt_reg;
      default:               rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : ddsl_top

// file: sim/ddsl_host_model.sv
/*
  Host serial port model: frames words with select low, data MSB first.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module ddsl_host_model (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // Period 64 ns; data set 12 ns before each falling edge
  task automatic frame(input logic [17:0] bits, input int n, input bit split);
    cs_n = 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #12 sclk = 1'b0;
      #32 sclk = 1'b1;
      #20;
      if (split && i == n - 8) #100;
    end
    #10 cs_n = 1'b1;
    din = ~din;
  endtask : frame

  // Clock edges with select high
  task automatic idle_clocks(input int n);
    repeat (n) begin
      din = ~din;
      #32 sclk = 1'b0;
      #32 sclk = 1'b1;
    end
  endtask : idle_clocks
endmodule : ddsl_host_model

// file: sim/ddsl_props.sv
/*
  Checker for the serial load block: bus response, commit pulse, latches.
  Sees only the ports of ddsl_top.
*/
`timescale 1ns/10ps
module ddsl_props (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Converter controls
  input wire logic [9:0]  dac_a_code,
  input wire logic [9:0]  dac_b_code,
  input wire logic        speed_fast,
  input wire logic        power_down,
  input wire logic [1:0]  ref_select,
  input wire logic        update_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
  a_chan_a_commit: assert property (!$stable(dac_a_code) |-> update_pulse)
    else $error("channel A changed without pulse");
  a_chan_b_commit: assert property (!$stable(dac_b_code) |-> update_pulse)
    else $error("channel B changed without pulse");
  a_ref_commit: assert property (!$stable(ref_select) |-> update_pulse)
    else $error("reference changed without pulse");
  a_mode_commit: assert property (!$stable({speed_fast, power_down}) |-> update_pulse)
    else $error("mode bits changed without pulse");
  a_pulse_single: assert property (update_pulse |=> !update_pulse)
    else $error("pulse longer than one cycle");
  a_reset_clear: assert property ($rose(hresetn) |-> dac_a_code == 10'h000 && dac_b_code == 10'h000
    && ref_select == 2'h0 && !speed_fast && !power_down) else $error("latches not clear");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");

  c_commit: cover property (update_pulse);
  c_ref_high: cover property (ref_select == 2'h2);
  c_fast_down: cover property (speed_fast && power_down);
endmodule : ddsl_props

bind ddsl_top ddsl_props i_ddsl_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .speed_fast(speed_fast), .power_down(power_down),
  .ref_select(ref_select), .update_pulse(update_pulse));

// file: sim/ddsl_top_tb.sv
/*
  Bench for the serial load block: host model frames, AHB-Lite access,
  expected latch state queued and compared at each update pulse.
  Assumes every commit gives one update pulse.
*/
`timescale 1ns/10ps
module ddsl_top_tb;
  typedef struct packed {
    logic [9:0] a;
    logic [9:0] b;
    logic [1:0] rf;
    logic       sp;
    logic       pw;
  } ddsl_exp_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, rd;
  logic [1:0]  htrans = 2'h0, ref_select;
  logic [2:0]  hsize = 3'h2;
  wire logic   hready;
  logic        hreadyout, hresp, sclk, cs_n, din, speed_fast, power_down, update_pulse;
  logic [9:0]  dac_a_code, dac_b_code, stage = 10'h000;
  ddsl_exp_t   cur = '0, q[$];
  int          num_errors = 0, total_checks = 0, words = 0;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  ddsl_top i_ddsl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .din(din), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
    .speed_fast(speed_fast), .power_down(power_down), .ref_select(ref_select), .update_pulse(update_pulse));
  ddsl_host_model i_ddsl_host_model (.sclk(sclk), .cs_n(cs_n), .din(din));

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic fail(input string msg);
    num_errors++;
    $display("ERROR %0t %s", $time, msg);
  endtask : fail

  task automatic check_out(input ddsl_exp_t e);
    total_checks++;
    if ({dac_a_code, dac_b_code, ref_select, speed_fast, power_down} !== e) fail("latch outputs differ");
  endtask : check_out

  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail("read data differs");
  endtask : check_rd

  // Outputs compared against the oldest note at each pulse
  always @(negedge hclk) begin
    if (hresetn && update_pulse === 1'b1) begin
      if (q.size() == 0) fail("commit with nothing sent");
      else check_out(q.pop_front());
    end
  end

  task automatic expect_word(input logic [15:0] w);
    case ({w[15], w[12]})
      2'b00: begin cur.b = w[11:2]; stage = w[11:2]; end
      2'b01: stage = w[11:2];
      2'b10: begin cur.a = w[11:2]; cur.b = stage; end
      default: cur.rf = w[1:0];
    endcase
    cur.sp = w[14];
    cur.pw = w[13];
    words++;
    q.push_back(cur);
  endtask : expect_word

  task automatic drain;
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge hclk);
    if (q.size() > 0) begin
      fail("commit timeout");
      print_verdict;
    end
    repeat (6) @(posedge hclk);
  endtask : drain

  task automatic put(input logic [15:0] w, input bit split);
    expect_word(w);
    #($urandom_range(63, 1));
    i_ddsl_host_model.frame({2'h0, w}, 16, split);
    drain;
  endtask : put

  task automatic wait_ready(inout int n);
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] d);
    int n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, ad};
    wait_ready(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n);
    d = hrdata;
    if (n >= 50) begin
      fail("bus timeout");
      print_verdict;
    end
  endtask : ahb

  initial begin
    #500000;
    fail("run timeout");
    print_verdict;
  end

  initial begin
    logic [15:0] w;
    w = 16'($urandom(50));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check_out('0);
    for (int k = 0; k < 8; k++) begin
      ahb(1'b0, 8'(k * 4), 32'h00000000, rd);
      check_rd(rd, (k == 5) ? 32'h00000001 : 32'h00000000);
    end
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      w = 16'($urandom);
      {w[15], w[12], w[1:0]} = 4'(k);
      put(w, k[0]);
    end
    $display("test targets done");
    i_ddsl_host_model.idle_clocks(6);
    w = {4'h9, 12'($urandom)};
    // Low nibble becomes the top of the short frame that follows
    w[3:0] = 4'h8;
    expect_word(w);
    i_ddsl_host_model.frame({w, 2'h3}, 18, 1'b0);
    drain;
    w = {4'h8, 12'($urandom)};
    expect_word(w);
    i_ddsl_host_model.frame({6'h00, w[11:0]}, 12, 1'b0);
    drain;
    $display("test framing done");
    w = 16'($urandom);
    expect_word(w);
    ahb(1'b1, ddsl_pkg::OFS_SW_LOAD, {16'h0000, w}, rd);
    drain;
    ahb(1'b1, ddsl_pkg::OFS_DAC_A, 32'hFFFFFFFF, rd);
    ahb(1'b0, ddsl_pkg::OFS_DAC_A, 32'h00000000, rd);
    check_rd(rd, {22'h000000, cur.a});
    ahb(1'b0, ddsl_pkg::OFS_LAST, 32'h00000000, rd);
    check_rd(rd, {16'h0000, w});
    ahb(1'b0, ddsl_pkg::OFS_COUNT, 32'h00000000, rd);
    check_rd(rd, 32'(words));
    ahb(1'b0, 8'h40, 32'h00000000, rd);
    check_rd(rd, 32'h00000000);
    // Link disabled: a serial word gives no pulse and no count
    ahb(1'b1, ddsl_pkg::OFS_CONTROL, 32'h00000000, rd);
    ahb(1'b0, ddsl_pkg::OFS_CONTROL, 32'h00000000, rd);
    check_rd(rd, 32'h00000000);
    i_ddsl_host_model.frame({2'h0, 16'($urandom)}, 16, 1'b0);
    drain;
    ahb(1'b0, ddsl_pkg::OFS_COUNT, 32'h00000000, rd);
    check_rd(rd, 32'(words));
    ahb(1'b1, ddsl_pkg::OFS_CONTROL, 32'h00000001, rd);
    $display("test registers done");
    repeat (8) put(16'($urandom), 1'($urandom));
    $display("test random done");
    print_verdict;
  end
endmodule : ddsl_top_tb
